/* File: cdms_regs.vh */
`ifndef CDMS_REGS_VH
`define CDMS_REGS_VH

// Register addresses in direct space
`define CDMS_STATUS_ADDR 8'hD0
`define CDMS_AUX_ADDR 8'hF0
`define CDMS_STACK_ADDR 8'h81

// Reset values
`define CDMS_STATUS_RST 8'h00
`define CDMS_AUX_RST 8'h00
`define CDMS_STACK_RST 8'h07

// Status word field positions
`define CDMS_CARRY_BIT 7
`define CDMS_NIB_BIT 6
`define CDMS_FLAG_ZERO_BIT 5
`define CDMS_BANK_HI 4
`define CDMS_BANK_LO 3
`define CDMS_WRAP_BIT 2
`define CDMS_FLAG_ONE_BIT 1
`define CDMS_PAR_BIT 0

// Data space layout
`define CDMS_UPPER_BASE 8'h80
`define CDMS_BITRAM_BASE 8'h20

// Access commands
`define CDMS_CMD_DIRECT 3'h0
`define CDMS_CMD_INDIRECT 3'h1
`define CDMS_CMD_REG 3'h2
`define CDMS_CMD_BIT 3'h3
`define CDMS_CMD_PUSH 3'h4
`define CDMS_CMD_POP 3'h5

// Lock byte per flash size variant
`define CDMS_VAR_16K 2'h0
`define CDMS_VAR_15K 2'h1
`define CDMS_VAR_8K 2'h2
`define CDMS_LOCK_16K 16'h3FFF
`define CDMS_LOCK_15K 16'h3BFF
`define CDMS_LOCK_8K 16'h1FFF

`endif

/* File: cdms_ram.v */
`timescale 1ns/1ns
module cdms_ram (
   // Clock
   input wire core_clk,
   // Port
   input wire [7:0] addr,
   input wire we,
   input wire [7:0] wdata,
   output reg [7:0] rdata_q
);

   reg [7:0] mem [0:255];

   always @(posedge core_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
   end

endmodule

/* File: cdms_core.v */
`timescale 1ns/1ns
`include "cdms_regs.vh"
module cdms_core #(
   parameter [1:0] FLASH_VARIANT = `CDMS_VAR_16K
) (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Access request
   input wire req,
   input wire [2:0] cmd,
   input wire we,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire bit_wval,
   input wire ri_sel,
   output wire busy,
   // Access answer
   output reg done_q,
   output reg [7:0] rd_data_q,
   output reg rd_bit_q,
   // Other special registers
   output wire sfr_req,
   output wire sfr_we,
   output wire [7:0] sfr_addr,
   output wire [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata,
   // Accumulator and arithmetic results
   input wire [7:0] acc_value,
   input wire arith_carry_we,
   input wire arith_carry,
   input wire arith_nib_we,
   input wire arith_nib,
   input wire arith_wrap_we,
   input wire arith_wrap,
   input wire aux_we,
   input wire [7:0] aux_wdata,
   // State
   output wire [7:0] program_status_word,
   output wire [7:0] auxiliary_operand_register,
   output wire [7:0] stack_top_pointer,
   output wire [1:0] register_bank_select,
   // Program memory routing
   input wire code_read_instruction,
   input wire external_move_instruction,
   input wire ext_write,
   input wire flash_write_enable,
   output reg route_flash_read_q,
   output reg route_xram_q,
   output reg route_flash_write_q,
   output reg [15:0] lock_byte_addr_q
);

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_PTR = 2'h1;
   localparam [1:0] S_EXEC = 2'h2;
   localparam [1:0] S_WAIT = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   function [7:0] merge_bit;
      input [7:0] v;
      input [2:0] pos;
      input b;
      reg [7:0] m;
      begin
         m = 8'h01 << pos;
         merge_bit = b ? (v | m) : (v & ~m);
      end
   endfunction

   function [7:0] bank_addr;
      input [1:0] bank;
      input [2:0] r;
      begin
         bank_addr = {3'h0, bank, r};
      end
   endfunction

   function [15:0] lock_addr;
      input [1:0] variant;
      begin
         case (variant)
            `CDMS_VAR_15K: lock_addr = `CDMS_LOCK_15K;
            `CDMS_VAR_8K: lock_addr = `CDMS_LOCK_8K;
            default: lock_addr = `CDMS_LOCK_16K;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   reg [1:0] state_q;
   reg we_q;
   reg [7:0] wdata_q;
   reg bval_q;
   reg isbit_q;
   reg [2:0] pos_q;
   reg [7:0] ea_q;
   reg ram_tgt_q;
   reg [7:0] stk_q;
   reg [7:0] aux_q;
   reg carry_q;
   reg nib_q;
   reg uflag0_q;
   reg [1:0] bank_q;
   reg wrap_q;
   reg uflag1_q;

   wire [7:0] ram_q;
   reg [7:0] ram_addr;
   reg ram_we;
   reg [7:0] ram_wd;
   wire parity;
   wire [7:0] status_val;
   wire hit_status;
   wire hit_aux;
   wire hit_stack;
   wire hit_own;
   reg [7:0] sfr_val;
   wire [7:0] sfr_new;

   assign parity = ^acc_value;
   assign status_val = {carry_q, nib_q, uflag0_q, bank_q, wrap_q, uflag1_q,
      parity};
   assign program_status_word = status_val;
   assign auxiliary_operand_register = aux_q;
   assign stack_top_pointer = stk_q;
   assign register_bank_select = bank_q;
   assign busy = (state_q != S_IDLE);

   assign hit_status = (ea_q == `CDMS_STATUS_ADDR);
   assign hit_aux = (ea_q == `CDMS_AUX_ADDR);
   assign hit_stack = (ea_q == `CDMS_STACK_ADDR);
   assign hit_own = hit_status | hit_aux | hit_stack;

   ////////////////////////////////////////////////////////////////////////
   // Special register side

   // direct upper addresses reach SFR space
   assign sfr_req = (state_q == S_EXEC) & ~ram_tgt_q & ~hit_own;
   assign sfr_we = sfr_req & we_q;
   assign sfr_addr = ea_q;
   assign sfr_wdata = sfr_new;

   always @* begin
      if (hit_status) begin
         sfr_val = status_val;
      end else if (hit_aux) begin
         sfr_val = aux_q;
      end else if (hit_stack) begin
         sfr_val = stk_q;
      end else begin
         sfr_val = sfr_rdata;
      end
   end

   // bit commands modify one bit only
   assign sfr_new = isbit_q ? merge_bit(sfr_val, pos_q, bval_q) : wdata_q;

   ////////////////////////////////////////////////////////////////////////
   // RAM port

   cdms_ram u_ram (
      .core_clk(core_clk),
      .addr(ram_addr),
      .we(ram_we),
      .wdata(ram_wd),
      .rdata_q(ram_q)
   );

   always @* begin
      ram_addr = ea_q;
      ram_we = 1'b0;
      ram_wd = wdata_q;
      case (state_q)
         S_IDLE: begin
            ram_addr = bank_addr(bank_q, {2'h0, ri_sel});
         end
         S_EXEC: begin
            ram_we = ram_tgt_q & we_q & ~isbit_q;
         end
         S_WAIT: begin
            ram_we = isbit_q & we_q;
            ram_wd = merge_bit(ram_q, pos_q, bval_q);
         end
         default: begin
            ram_addr = ea_q;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         we_q <= 1'b0;
         wdata_q <= 8'h00;
         bval_q <= 1'b0;
         isbit_q <= 1'b0;
         pos_q <= 3'h0;
         ea_q <= 8'h00;
         ram_tgt_q <= 1'b0;
         stk_q <= `CDMS_STACK_RST;
         done_q <= 1'b0;
         rd_data_q <= 8'h00;
         rd_bit_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (req) begin
                  we_q <= we;
                  wdata_q <= wdata;
                  bval_q <= bit_wval;
                  isbit_q <= 1'b0;
                  pos_q <= addr[2:0];
                  state_q <= S_EXEC;
                  case (cmd)
                     `CDMS_CMD_INDIRECT: begin
                        state_q <= S_PTR;
                     end
                     `CDMS_CMD_REG: begin
                        ea_q <= bank_addr(bank_q, addr[2:0]);
                        ram_tgt_q <= 1'b1;
                     end
                     `CDMS_CMD_BIT: begin
                        isbit_q <= 1'b1;
                        if (addr < `CDMS_UPPER_BASE) begin
                           ea_q <= `CDMS_BITRAM_BASE + {4'h0, addr[6:3]};
                           ram_tgt_q <= 1'b1;
                        end else begin
                           ea_q <= {addr[7:3], 3'h0};
                           ram_tgt_q <= 1'b0;
                        end
                     end
                     `CDMS_CMD_PUSH: begin
                        ea_q <= stk_q + 8'h01;
                        stk_q <= stk_q + 8'h01;
                        we_q <= 1'b1;
                        ram_tgt_q <= 1'b1;
                     end
                     `CDMS_CMD_POP: begin
                        ea_q <= stk_q;
                        stk_q <= stk_q - 8'h01;
                        we_q <= 1'b0;
                        ram_tgt_q <= 1'b1;
                     end
                     default: begin
                        ea_q <= addr;
                        // lower half is RAM when direct
                        ram_tgt_q <= (addr < `CDMS_UPPER_BASE);
                     end
                  endcase
               end
            end
            S_PTR: begin
               // indirect upper addresses stay in RAM
               ea_q <= ram_q;
               ram_tgt_q <= 1'b1;
               state_q <= S_EXEC;
            end
            S_EXEC: begin
               if (ram_tgt_q) begin
                  if (we_q && !isbit_q) begin
                     done_q <= 1'b1;
                     rd_data_q <= wdata_q;
                     rd_bit_q <= wdata_q[pos_q];
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_WAIT;
                  end
               end else begin
                  done_q <= 1'b1;
                  rd_data_q <= sfr_val;
                  rd_bit_q <= sfr_val[pos_q];
                  if (we_q && hit_stack) begin
                     stk_q <= sfr_new;
                  end
                  state_q <= S_IDLE;
               end
            end
            S_WAIT: begin
               done_q <= 1'b1;
               rd_data_q <= ram_q;
               rd_bit_q <= ram_q[pos_q];
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status word and auxiliary register

   wire sw_status;
   wire sw_aux;

   assign sw_status = (state_q == S_EXEC) & ~ram_tgt_q & we_q & hit_status;
   assign sw_aux = (state_q == S_EXEC) & ~ram_tgt_q & we_q & hit_aux;

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         carry_q <= 1'b0;
         nib_q <= 1'b0;
         uflag0_q <= 1'b0;
         bank_q <= 2'h0;
         wrap_q <= 1'b0;
         uflag1_q <= 1'b0;
         aux_q <= `CDMS_AUX_RST;
      end else begin
         if (sw_status) begin
            carry_q <= sfr_new[`CDMS_CARRY_BIT];
            nib_q <= sfr_new[`CDMS_NIB_BIT];
            uflag0_q <= sfr_new[`CDMS_FLAG_ZERO_BIT];
            uflag1_q <= sfr_new[`CDMS_FLAG_ONE_BIT];
            bank_q <= sfr_new[`CDMS_BANK_HI:`CDMS_BANK_LO];
            wrap_q <= sfr_new[`CDMS_WRAP_BIT];
         end
         if (arith_carry_we) begin
            carry_q <= arith_carry;
         end
         if (arith_nib_we) begin
            nib_q <= arith_nib;
         end
         if (arith_wrap_we) begin
            wrap_q <= arith_wrap;
         end
         if (sw_aux) begin
            aux_q <= sfr_new;
         end
         if (aux_we) begin
            aux_q <= aux_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Program memory routing

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         route_flash_read_q <= 1'b0;
         route_xram_q <= 1'b0;
         route_flash_write_q <= 1'b0;
         lock_byte_addr_q <= `CDMS_LOCK_16K;
      end else begin
         // code reads always go to flash
         route_flash_read_q <= code_read_instruction;
         // moves use XRAM unless they are writes with flash writes on
         route_xram_q <= external_move_instruction &
            ~(ext_write & flash_write_enable);
         route_flash_write_q <= external_move_instruction &
            ext_write & flash_write_enable;
         // lock byte is last user byte
         lock_byte_addr_q <= lock_addr(FLASH_VARIANT);
      end
   end

endmodule

/* File: cdms_core_assertions.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module cdms_core_chk (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Access request
   input wire req,
   input wire [2:0] cmd,
   input wire busy,
   // Flag inputs
   input wire [7:0] acc_value,
   input wire arith_carry_we,
   input wire arith_carry,
   input wire arith_nib_we,
   input wire arith_nib,
   input wire arith_wrap_we,
   input wire arith_wrap,
   input wire aux_we,
   input wire [7:0] aux_wdata,
   // State
   input wire [7:0] program_status_word,
   input wire [7:0] auxiliary_operand_register,
   input wire [7:0] stack_top_pointer,
   input wire [1:0] register_bank_select
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire [7:0] stat = program_status_word;
   wire [7:0] stk = stack_top_pointer;
   wire take = req && !busy;
   ////////////////////////////////////////////////////////////
   parity_follows_a: assert property (
      stat[0] == ^acc_value) else $error("parity flag wrong");
   carry_update_a: assert property (
      arith_carry_we |=> stat[7] == $past(arith_carry))
      else $error("carry flag not updated");
   nibble_carry_a: assert property (
      arith_nib_we && arith_nib |-> ##1 stat[6])
      else $error("nibble carry not set");
   wrap_flag_a: assert property (
      arith_wrap_we && !arith_wrap |=> !stat[2])
      else $error("overflow flag not cleared");
   aux_load_a: assert property (
      aux_we |=> auxiliary_operand_register == $past(aux_wdata))
      else $error("aux register not loaded");
   bank_hold_a: assert property (
      !busy |=> $stable(register_bank_select))
      else $error("bank select changed while idle");
   user_flags_a: assert property (
      !busy |=> $stable({stat[5], stat[1]}))
      else $error("user flag changed while idle");
   push_pointer_a: assert property (
      take && cmd == 3'h4 |=> stk == $past(stk) + 8'h01)
      else $error("push did not bump pointer");
   pop_pointer_a: assert property (
      take && cmd == 3'h5 |=> stk == $past(stk) - 8'h01)
      else $error("pop did not drop pointer");
endmodule

bind cdms_core cdms_core_chk chk_u (.core_clk, .nrst, .req, .cmd, .busy,
   .acc_value, .arith_carry_we, .arith_carry, .arith_nib_we, .arith_nib,
   .arith_wrap_we, .arith_wrap, .aux_we, .aux_wdata, .program_status_word,
   .auxiliary_operand_register, .stack_top_pointer, .register_bank_select);

/* File: cdms_sfr_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module cdms_sfr_model (
   // Clock
   input wire core_clk,
   // Special register side
   input wire sfr_req,
   input wire sfr_we,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   output wire [7:0] sfr_rdata
);
   logic [7:0] m [128:255];
   // Read data depends on address only
   assign sfr_rdata = m[{1'b1, sfr_addr[6:0]}];
   initial begin
      for (int i = 128; i < 256; i++) m[i] = ~i[7:0];
   end
   always @(posedge core_clk) begin
      if (sfr_req && sfr_we) m[{1'b1, sfr_addr[6:0]}] <= sfr_wdata;
   end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module tb_top;
   logic core_clk = 0, nrst = 0, req = 0, we = 0, bit_wval = 0;
   logic ri_sel = 0, arith_carry_we = 0, arith_carry = 0;
   logic arith_nib_we = 0, arith_nib = 0, arith_wrap_we = 0;
   logic arith_wrap = 0, aux_we = 0;
   logic code_read_instruction = 0, external_move_instruction = 0;
   logic ext_write = 0, flash_write_enable = 0;
   logic [2:0] cmd = 0;
   logic [7:0] addr = 0, wdata = 0, acc_value = 0, aux_wdata = 0;
   logic busy, done_q, rd_bit_q, sfr_req, sfr_we;
   logic route_flash_read_q, route_xram_q, route_flash_write_q;
   logic [7:0] rd_data_q, sfr_addr, sfr_wdata, sfr_rdata;
   logic [7:0] program_status_word, auxiliary_operand_register;
   logic [7:0] stack_top_pointer;
   logic [1:0] register_bank_select;
   logic [15:0] lock_byte_addr_q;
   logic [7:0] q[$];
   logic [7:0] r, v;
   int errors = 0, n_checks = 0;
   cdms_core dut_u (
      .core_clk(core_clk), .nrst(nrst), .req(req), .cmd(cmd), .we(we),
      .addr(addr), .wdata(wdata), .bit_wval(bit_wval), .ri_sel(ri_sel),
      .busy(busy), .done_q(done_q), .rd_data_q(rd_data_q),
      .rd_bit_q(rd_bit_q), .sfr_req(sfr_req), .sfr_we(sfr_we),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .acc_value(acc_value), .arith_carry_we(arith_carry_we),
      .arith_carry(arith_carry), .arith_nib_we(arith_nib_we),
      .arith_nib(arith_nib), .arith_wrap_we(arith_wrap_we),
      .arith_wrap(arith_wrap), .aux_we(aux_we), .aux_wdata(aux_wdata),
      .program_status_word(program_status_word),
      .auxiliary_operand_register(auxiliary_operand_register),
      .stack_top_pointer(stack_top_pointer),
      .register_bank_select(register_bank_select),
      .code_read_instruction(code_read_instruction),
      .external_move_instruction(external_move_instruction),
      .ext_write(ext_write), .flash_write_enable(flash_write_enable),
      .route_flash_read_q(route_flash_read_q),
      .route_xram_q(route_xram_q),
      .route_flash_write_q(route_flash_write_q),
      .lock_byte_addr_q(lock_byte_addr_q)
   );
   cdms_sfr_model sfr_u (
      .core_clk(core_clk), .sfr_req(sfr_req), .sfr_we(sfr_we),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata)
   );
   always #20 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One access; ck queues the expected answer
   task automatic acc(input [2:0] c, input w, input [7:0] a, d,
      input ck, input [7:0] e);
      int n;
      n = 0;
      @(negedge core_clk);
      req = 1;
      cmd = c;
      we = w;
      addr = a;
      wdata = d;
      bit_wval = d[0];
      if (ck) q.push_back(e);
      @(negedge core_clk);
      req = 0;
      chk(busy, 1'b1);
      while (done_q !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 20) begin
         errors++;
         wrap_up;
      end
   endtask
   // Answer watcher
   always @(negedge core_clk) begin
      if (done_q === 1'b1 && q.size() > 0)
         chk(rd_data_q, q.pop_front());
   end
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hD0B6));
      repeat (16) @(negedge core_clk);
      nrst = 1;
      @(negedge core_clk);
      chk(stack_top_pointer, 8'h07);
      chk(program_status_word, 8'h00);
      chk(auxiliary_operand_register, 8'h00);
      chk(lock_byte_addr_q, 16'h3FFF);
      $display("reset test done");
      r = $urandom;
      acc(3'h4, 1, 0, r, 0, 0);
      chk(stack_top_pointer, 8'h08);
      acc(3'h0, 0, 8'h08, 0, 1, r);
      acc(3'h5, 0, 0, 0, 1, r);
      acc(3'h0, 1, 8'h81, 8'hFF, 0, 0);
      v = $urandom;
      acc(3'h4, 1, 0, v, 0, 0);
      chk(stack_top_pointer, 8'h00);
      acc(3'h0, 0, 8'h00, 0, 1, v);
      acc(3'h0, 1, 8'h81, 8'h07, 0, 0);
      $display("stack test done");
      acc(3'h0, 1, 8'hD0, 8'hFF, 0, 0);
      acc(3'h0, 0, 8'hD0, 0, 1, 8'hFE);
      for (int b = 0; b < 4; b++) begin
         acc(3'h0, 1, 8'hD0, 8'(b << 3), 0, 0);
         chk(register_bank_select, 16'(b));
         r = $urandom;
         acc(3'h2, 1, 8'(b + 2), r, 0, 0);
         acc(3'h0, 0, 8'(b * 9 + 2), 0, 1, r);
      end
      acc(3'h0, 1, 8'hD0, 8'h00, 0, 0);
      $display("bank test done");
      acc(3'h2, 1, 0, 8'h90, 0, 0);
      acc(3'h0, 0, 8'h90, 0, 1, 8'h6F);
      r = $urandom;
      v = $urandom;
      acc(3'h0, 1, 8'h90, r, 0, 0);
      acc(3'h1, 1, 0, v, 0, 0);
      acc(3'h1, 0, 0, 0, 1, v);
      acc(3'h0, 0, 8'h90, 0, 1, r);
      acc(3'h2, 1, 1, 8'h30, 0, 0);
      ri_sel = 1;
      acc(3'h1, 1, 0, r, 0, 0);
      acc(3'h0, 0, 8'h30, 0, 1, r);
      $display("indirect test done");
      v = $urandom % 128;
      acc(3'h0, 1, 8'h20 + v[6:3], 8'h00, 0, 0);
      acc(3'h3, 1, v, 8'h01, 0, 0);
      acc(3'h0, 0, 8'h20 + v[6:3], 0, 1, 8'h01 << v[2:0]);
      acc(3'h3, 0, v, 0, 1, 8'h01 << v[2:0]);
      chk(rd_bit_q, 1'b1);
      acc(3'h3, 1, 8'hD5, 8'h01, 0, 0);
      acc(3'h0, 0, 8'hD0, 0, 1, 8'h20);
      $display("bit test done");
      repeat (8) begin
         r = $urandom;
         acc_value = $urandom;
         aux_wdata = $urandom;
         {arith_carry, arith_nib, arith_wrap} = r[2:0];
         {arith_carry_we, arith_nib_we, arith_wrap_we, aux_we} = 4'hF;
         @(negedge core_clk);
         {arith_carry_we, arith_nib_we, arith_wrap_we, aux_we} = 4'h0;
         chk({program_status_word[7:6], program_status_word[2]},
            r[2:0]);
         chk(program_status_word[0], ^acc_value);
         chk(auxiliary_operand_register, aux_wdata);
         @(negedge core_clk);
         chk({program_status_word[7:6], program_status_word[2]},
            r[2:0]);
         chk(auxiliary_operand_register, aux_wdata);
      end
      $display("flag test done");
      code_read_instruction = 1;
      external_move_instruction = 1;
      @(negedge core_clk);
      chk({route_flash_read_q, route_xram_q}, 2'h3);
      ext_write = 1;
      flash_write_enable = 1;
      @(negedge core_clk);
      chk({route_xram_q, route_flash_write_q}, 2'h1);
      $display("route test done");
      chk(q.size(), 0);
      wrap_up;
   end
endmodule
